// *** tcp_phase_sampler.sv ***
module tcp_phase_sampler (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic sample_en_i,
  input wire logic src_i,
  output logic level_o,
  output logic rise_o
);

  // ==========================================================
  // Sampling on Q2 and Q4 only
  logic level_reg;
  logic level_prev_reg;
  logic rise_reg;

  // Source caught only at the chosen phases, so short glitches between miss.
  // Reset high: a source already high at release is not taken as a fresh edge
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_reg <= 1'b1;
    end else if (sample_en_i) begin
      level_reg <= src_i;
    end
  end

  // Sampled level one clock back, same reset level as the sample
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_prev_reg <= 1'b1;
    end else begin
      level_prev_reg <= level_reg;
    end
  end

  // One pulse per new high sample; the extra stage keeps the count three or four clocks behind src_i
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_reg <= 1'b0;
    end else begin
      rise_reg <= level_reg && !level_prev_reg;
    end
  end

  assign level_o = level_reg;
  assign rise_o = rise_reg;

  // ==========================================================
  // Checks
  a_sample_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !sample_en_i |=> $stable(level_reg))
    else $error("sampled level moved outside Q2/Q4");

endmodule

// *** tcp_pkg.sv ***
package tcp_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] COUNT_ADDR = 8'h01;
  localparam logic [7:0] OPTION_ADDR = 8'h10;
  localparam logic [7:0] DIR_ADDR = 8'h11;

  // ==========================================================
  // Option fields and reset values
  localparam int OPT_WAKE_BIT = 7;
  localparam int OPT_PULL_BIT = 6;
  localparam int OPT_CS_BIT = 5;
  localparam int OPT_SE_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_PS_HI = 2;
  localparam int OPT_PS_LO = 0;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [3:0] DIR_RESET = 4'hF;
  localparam int EXT_PIN_IDX = 2;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================
  // Timing: one oscillator period per clock, four per instruction
  localparam int CLK_PERIOD_NS = 5;
  localparam int TOSC_NS = 5;
  localparam int TOSC_PER_INSTR = 4;
  localparam int CLK_PER_INSTR = (TOSC_PER_INSTR * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INHIBIT_INSTR = 2;
  localparam logic [3:0] INHIBIT_CLKS = 4'(INHIBIT_INSTR * CLK_PER_INSTR);

  // ==========================================================
  // Internal phase clocks of an instruction cycle
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } tcp_phase_type;

endpackage

// *** tcp_prescaler.sv ***
module tcp_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic [2:0] ratio_i,
  output logic tap_o,
  output logic tick_o,
  output logic [WIDTH-1:0] count_o
);

  // ==========================================================
  // Shared divider, invisible to software
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] low_mask;

  // Ratio n keeps bits n..0, giving division by 2^(n+1)
  always_comb begin
    low_mask = WIDTH'((2 << ratio_i) - 1);
  end

  // Clear dominates a step; reset leaves all zeros
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= '0;
    end else if (clear_i) begin
      cnt_reg <= '0;
    end else if (step_i) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick_o = step_i && !clear_i && ((cnt_reg & low_mask) == low_mask);
  assign tap_o = cnt_reg[ratio_i]; // Square wave, symmetric by construction
  assign count_o = cnt_reg;

  // ==========================================================
  // Checks
  a_clear_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    clear_i |=> cnt_reg == '0)
    else $error("prescaler not cleared");

  a_step_count: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    step_i && !clear_i |=> cnt_reg == WIDTH'($past(cnt_reg) + 1'b1))
    else $error("prescaler step lost");

endmodule

// *** tcp_pulse_source.sv ***
module tcp_pulse_source (
  input wire logic ref_clk_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // External edge source
  // Pin starts low so the first edge is always a rising one
  initial begin
    pin_o = 1'b0;
  end

  // One flip just after a clock edge, then held h clocks (h >= 2 except for lone edges)
  task automatic step(input int h);
    @(posedge ref_clk_i);
    pin_o <= ~pin_o;
    repeat (h - 1) @(posedge ref_clk_i);
  endtask
endmodule

// *** tcp_timer.sv ***
// What this block does
// - Source select clear, no prescaler: count rises once every instruction cycle.
// - Counting is held off for two instruction cycles after a count write.
// - Source select set: count follows selected edge of the external pin.
// - Edge select clear counts rising edges; set counts falling edges.
// - Assign bit clear gives prescaler to timer, set gives it to watchdog.
// - Assign bit is option bit 3; ratio field is bits 2 to 0.
// - Prescaler on timer divides by 2 up to 256, doubling per step.
// - Prescaler is an 8-bit counter with no software read or write path.
// - With prescaler on timer, any count write clears the prescaler.
// - With prescaler on watchdog, clear-watchdog clears prescaler and watchdog.
// - Every reset leaves the prescaler at zero.
// - No prescaler on timer: external input passes straight to sampling.
// - Counter mode with prescaler: pin divided first, symmetric output sampled.
// - Prescaler output is sampled on phases Q2 and Q4.
// - Count moves three to five oscillator periods after an input change.
// - Source select set forces the external pin to input.
module tcp_timer #(
  parameter int COUNT_WIDTH = 8,
  parameter int PRESC_WIDTH = 8,
  parameter int PIN_COUNT = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext_count_pin_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic wdt_base_tick_i,
  output logic wdt_tick_o,
  output logic wdt_clear_o,
  output logic [PIN_COUNT-1:0] pin_oe_o,
  output logic pullup_disable_o,
  output logic pin_wake_disable_o
);

  // ==========================================================
  // Address decode
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction

  logic wr_count;
  logic wr_option;
  logic wr_dir;

  // Decode of write strobes
  always_comb begin
    wr_count = 1'b0;
    wr_option = 1'b0;
    wr_dir = 1'b0;
    if (wr_i && addr_is(addr_i, tcp_pkg::COUNT_ADDR)) begin
      wr_count = 1'b1;
    end else if (wr_i && addr_is(addr_i, tcp_pkg::OPTION_ADDR)) begin
      wr_option = 1'b1;
    end else if (wr_i && addr_is(addr_i, tcp_pkg::DIR_ADDR)) begin
      wr_dir = 1'b1;
    end
  end

  // ==========================================================
  // Configuration registers
  logic [7:0] option_config_reg;
  logic [PIN_COUNT-1:0] pin_direction_reg;
  logic clock_source_sel;
  logic source_edge_sel;
  logic prescaler_assign;
  logic [2:0] prescale_ratio;

  // Write-only option register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      option_config_reg <= tcp_pkg::OPTION_RESET;
    end else if (wr_option) begin
      option_config_reg <= wdata_i;
    end
  end

  // Write-only direction register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_direction_reg <= PIN_COUNT'(tcp_pkg::DIR_RESET);
    end else if (wr_dir) begin
      pin_direction_reg <= wdata_i[PIN_COUNT-1:0];
    end
  end

  // Field split
  assign clock_source_sel = option_config_reg[tcp_pkg::OPT_CS_BIT];
  assign source_edge_sel = option_config_reg[tcp_pkg::OPT_SE_BIT];
  assign prescaler_assign = option_config_reg[tcp_pkg::OPT_PSA_BIT];
  assign prescale_ratio = option_config_reg[tcp_pkg::OPT_PS_HI:tcp_pkg::OPT_PS_LO];

  // ==========================================================
  // Instruction phase sequencer
  tcp_pkg::tcp_phase_type phase_reg;
  tcp_pkg::tcp_phase_type phase_next;

  // Q1 to Q4 then around again
  always_comb begin
    case (phase_reg)
      tcp_pkg::PH_Q1: phase_next = tcp_pkg::PH_Q2;
      tcp_pkg::PH_Q2: phase_next = tcp_pkg::PH_Q3;
      tcp_pkg::PH_Q3: phase_next = tcp_pkg::PH_Q4;
      default: phase_next = tcp_pkg::PH_Q1;
    endcase
  end

  // Phase state
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_reg <= tcp_pkg::PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  logic instr_end;
  logic sample_phase;
  assign instr_end = (phase_reg == tcp_pkg::PH_Q4);
  assign sample_phase = (phase_reg == tcp_pkg::PH_Q2) || (phase_reg == tcp_pkg::PH_Q4);

  // ==========================================================
  // External source and prescaler
  logic src_raw;
  logic src_prev_reg;
  logic src_edge;
  logic presc_clear;
  logic presc_step;
  logic presc_tap;
  logic presc_tick;
  logic [PRESC_WIDTH-1:0] presc_count;

  // Falling edges turned into rising ones by inversion
  assign src_raw = ext_count_pin_i ^ source_edge_sel;

  // Previous pin level for the divider's edge step
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_raw;
    end
  end

  assign src_edge = src_raw && !src_prev_reg;

  // Divider clear by whichever user owns it
  assign presc_clear = (wr_count && !prescaler_assign)
    || (clear_watchdog_instr_i && prescaler_assign);

  // Divider step source, never two owners at once
  always_comb begin
    if (prescaler_assign) begin
      presc_step = wdt_base_tick_i;
    end else if (clock_source_sel) begin
      presc_step = src_edge;
    end else begin
      presc_step = instr_end;
    end
  end

  tcp_prescaler #(
    .WIDTH(PRESC_WIDTH)
  ) u_prescaler (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .clear_i(presc_clear),
    .step_i(presc_step),
    .ratio_i(prescale_ratio),
    .tap_o(presc_tap),
    .tick_o(presc_tick),
    .count_o(presc_count)
  );

  // ==========================================================
  // Synchronisation of the counter-mode source
  logic sync_src;
  logic sync_rise;

  // Bypass passes the pin straight through when the divider is elsewhere
  assign sync_src = prescaler_assign ? src_raw : presc_tap;

  tcp_phase_sampler u_sampler (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .sample_en_i(sample_phase),
    .src_i(sync_src),
    .level_o(),
    .rise_o(sync_rise)
  );

  // ==========================================================
  // Count register
  logic [COUNT_WIDTH-1:0] count_value_reg;
  logic [3:0] inhibit_reg;
  logic inc_src;
  logic inc_ok;

  // Increment cause per mode
  always_comb begin
    if (clock_source_sel) begin
      inc_src = sync_rise;
    end else if (prescaler_assign) begin
      inc_src = instr_end;
    end else begin
      inc_src = presc_tick;
    end
  end

  assign inc_ok = inc_src && (inhibit_reg == '0) && !wr_count;

  // Write hold-off, in clocks; lost increments are the user's to adjust for
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inhibit_reg <= '0;
    end else if (wr_count) begin
      inhibit_reg <= tcp_pkg::INHIBIT_CLKS;
    end else if (inhibit_reg != '0) begin
      inhibit_reg <= inhibit_reg - 1'b1;
    end
  end

  // Write wins over an increment in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_value_reg <= COUNT_WIDTH'(tcp_pkg::COUNT_RESET);
    end else if (wr_count) begin
      count_value_reg <= wdata_i[COUNT_WIDTH-1:0];
    end else if (inc_ok) begin
      count_value_reg <= count_value_reg + 1'b1;
    end
  end

  // ==========================================================
  // Outputs, all registered
  logic [7:0] rdata_reg;
  logic wdt_tick_reg;
  logic wdt_clear_reg;
  logic [PIN_COUNT-1:0] pin_oe_reg;
  logic [7:0] rdata_next;

  // Only the count reads back; other addresses read zero
  always_comb begin
    rdata_next = tcp_pkg::READ_ZERO;
    if (rd_i && addr_is(addr_i, tcp_pkg::COUNT_ADDR)) begin
      rdata_next = 8'(count_value_reg);
    end
  end

  // Read data for one cycle only
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= tcp_pkg::READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Watchdog gets divided ticks only while it owns the divider
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdt_tick_reg <= 1'b0;
      wdt_clear_reg <= 1'b0;
    end else begin
      wdt_tick_reg <= prescaler_assign ? presc_tick : wdt_base_tick_i;
      wdt_clear_reg <= clear_watchdog_instr_i;
    end
  end

  // Drivers on where direction bit is clear; counter mode forces pin to input
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_oe_reg <= '0;
    end else begin
      pin_oe_reg <= ~pin_direction_reg;
      if (clock_source_sel) begin
        pin_oe_reg[tcp_pkg::EXT_PIN_IDX] <= 1'b0;
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign wdt_tick_o = wdt_tick_reg;
  assign wdt_clear_o = wdt_clear_reg;
  assign pin_oe_o = pin_oe_reg;
  assign pullup_disable_o = option_config_reg[tcp_pkg::OPT_PULL_BIT];
  assign pin_wake_disable_o = option_config_reg[tcp_pkg::OPT_WAKE_BIT];

  // ==========================================================
  // Checks
  sequence s_count_write;
    wr_count ##1 (!wr_count) [*7];
  endsequence

  a_write_holdoff: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    s_count_write |-> count_value_reg == COUNT_WIDTH'($past(wdata_i, 7)))
    else $error("count moved during write hold-off");

  a_holdoff_len: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_count |=> inhibit_reg == tcp_pkg::INHIBIT_CLKS)
    else $error("hold-off length wrong");

  a_timer_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !clock_source_sel && prescaler_assign && instr_end && inhibit_reg == '0 && !wr_count
    |=> count_value_reg == COUNT_WIDTH'($past(count_value_reg) + 1'b1))
    else $error("timer mode missed an instruction cycle");

  a_timer_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !clock_source_sel && prescaler_assign && !instr_end && !wr_count
    |=> $stable(count_value_reg))
    else $error("timer counted off the instruction boundary");

  a_count_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    inc_ok && (&count_value_reg) |=> count_value_reg == '0)
    else $error("count did not wrap to zero");

  a_presc_write_clr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_count && !prescaler_assign |=> presc_count == '0)
    else $error("count write left prescaler running");

  a_wdt_only_owner: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    prescaler_assign && !presc_tick |=> !wdt_tick_o)
    else $error("watchdog tick without prescaler wrap");

  a_pin_forced_in: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    clock_source_sel |=> !pin_oe_o[tcp_pkg::EXT_PIN_IDX])
    else $error("external pin driven in counter mode");

  a_read_count: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_i && addr_is(addr_i, tcp_pkg::COUNT_ADDR) |=> rdata_o == 8'($past(count_value_reg)))
    else $error("count read back wrong");

  a_edge_delay: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    clock_source_sel && prescaler_assign && sync_rise && inhibit_reg == '0 && !wr_count
    |=> count_value_reg == COUNT_WIDTH'($past(count_value_reg) + 1'b1))
    else $error("counter mode missed a synchronised edge");

endmodule

// *** test_tcp_timer.sv ***
module test_tcp_timer;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(nm, ex, got) begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
  end

  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic clr_i = 1'b0;
  logic base_i = 1'b0;
  logic pin;
  logic [7:0] rdata_o;
  logic wdt_tick_o;
  logic wdt_clear_o;
  logic [3:0] pin_oe_o;
  logic pullup_o;
  logic wake_o;
  int fail_count = 0;
  int total_checks = 0;
  int ticks_seen = 0;
  int e0;
  int e;
  logic [31:0] seed = 32'h79b8c471;
  logic [7:0] v;
  logic [7:0] a;
  logic [7:0] b;
  logic l;

  // ==========================================================
  // Clock, design and edge source
  always #2.5 ref_clk_i = ~ref_clk_i;

  tcp_timer i_tcp_timer (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .ext_count_pin_i(pin),
    .clear_watchdog_instr_i(clr_i),
    .wdt_base_tick_i(base_i),
    .wdt_tick_o(wdt_tick_o),
    .wdt_clear_o(wdt_clear_o),
    .pin_oe_o(pin_oe_o),
    .pullup_disable_o(pullup_o),
    .pin_wake_disable_o(wake_o)
  );

  tcp_pulse_source i_tcp_pulse_source (
    .ref_clk_i(ref_clk_i),
    .pin_o(pin)
  );

  // Watchdog tick pulses are registered, so sampling at the edge is race free
  always @(posedge ref_clk_i) begin
    if (wdt_tick_o === 1'b1) ticks_seen++;
  end

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic int f_div(input int n);
    return 1 << (n + 1);
  endfunction

  // Edges alternate from level lv; counts the ones of the chosen polarity
  function automatic int f_edges(input logic lv, input int n, input logic se);
    int r;
    r = lv ? n / 2 : (n + 1) / 2;
    return se ? n - r : r;
  endfunction

  // ==========================================================
  // Bus and pulse drivers
  task automatic waitc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic bt(input int k);
    repeat (k) begin
      @(posedge ref_clk_i);
      base_i <= 1'b1;
      @(posedge ref_clk_i);
      base_i <= 1'b0;
    end
    waitc(3);
  endtask

  task automatic cw;
    @(posedge ref_clk_i);
    clr_i <= 1'b1;
    @(posedge ref_clk_i);
    clr_i <= 1'b0;
    #1 `CHK("wdt_clear", 1'b1, wdt_clear_o)
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is near 5.5k clocks; this leaves wide margin
  initial begin
    #300us;
    fail_count++;
    complete_run();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    waitc(2);
    `CHK("oe_reset", 4'h0, pin_oe_o)
    `CHK("pullup_reset", 1'b1, pullup_o)
    // Pin idles low under falling-edge select: no edge may be counted at release
    rd(tcp_pkg::COUNT_ADDR, a);
    `CHK("count_reset", tcp_pkg::COUNT_RESET, a)
    // Reset option gives the prescaler to the watchdog at 1:256
    bt(255);
    `CHK("wdt_after_reset", 0, ticks_seen)
    bt(1);
    `CHK("wdt_first_wrap", 1, ticks_seen)
    rd(tcp_pkg::OPTION_ADDR, a);
    `CHK("option_unreadable", 8'h00, a)
    rd(8'hFF, a);
    `CHK("unmapped_read", 8'h00, a)
    wr(tcp_pkg::DIR_ADDR, 8'h00);
    waitc(2);
    `CHK("oe_forced", 4'hB, pin_oe_o)
    wr(tcp_pkg::OPTION_ADDR, 8'h08);
    waitc(2);
    `CHK("oe_free", 4'hF, pin_oe_o)
    `CHK("pullup_bit", 1'b0, pullup_o)
    `CHK("wake_bit", 1'b0, wake_o)
    rd(tcp_pkg::COUNT_ADDR, a);
    waitc(38);
    rd(tcp_pkg::COUNT_ADDR, b);
    `CHK("timer_rate", 8'(a + 8'h0A), b)
    // Hold-off after a write, first value crosses the top
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 8'hFE : seed[7:0];
      wr(tcp_pkg::COUNT_ADDR, v);
      waitc(5);
      rd(tcp_pkg::COUNT_ADDR, a);
      `CHK("count_held", v, a)
      waitc(14);
      rd(tcp_pkg::COUNT_ADDR, b);
      `CHK("count_late", 1'b1, (b === 8'(v + 8'h03)) || (b === 8'(v + 8'h04)))
    end
    // Every ratio with the prescaler on the timer, watchdog cleared before the move
    cw();
    for (int n = 0; n < 8; n++) begin
      wr(tcp_pkg::OPTION_ADDR, 8'(n));
      wr(tcp_pkg::COUNT_ADDR, 8'h00);
      waitc(12);
      rd(tcp_pkg::COUNT_ADDR, a);
      waitc(8 * f_div(n) - 2);
      rd(tcp_pkg::COUNT_ADDR, b);
      `CHK("timer_ratio", 8'(a + 8'h02), b)
    end
    e0 = ticks_seen;
    bt(3);
    `CHK("wdt_unscaled", e0 + 3, ticks_seen)
    // Count writes restart the prescaler, so 1:8 never wraps in 22 clocks
    wr(tcp_pkg::OPTION_ADDR, 8'h02);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      waitc(int'(seed[4:0]));
      wr(tcp_pkg::COUNT_ADDR, 8'h00);
      waitc(20);
      rd(tcp_pkg::COUNT_ADDR, a);
      `CHK("presc_cleared", 8'h00, a)
    end
    // Move the prescaler to the watchdog at 1:4
    cw();
    wr(tcp_pkg::COUNT_ADDR, 8'h00);
    wr(tcp_pkg::OPTION_ADDR, 8'h09);
    cw();
    e0 = ticks_seen;
    bt(3);
    `CHK("wdt_ratio", e0, ticks_seen)
    bt(1);
    `CHK("wdt_wrap", e0 + 1, ticks_seen)
    bt(2);
    cw();
    bt(3);
    `CHK("wdt_restart", e0 + 1, ticks_seen)
    bt(1);
    `CHK("wdt_wrap2", e0 + 2, ticks_seen)
    // Counter mode, both edge choices, random edge counts
    for (int se = 0; se < 2; se++) begin
      wr(tcp_pkg::OPTION_ADDR, se ? 8'h39 : 8'h29);
      waitc(10);
      rd(tcp_pkg::COUNT_ADDR, a);
      seed = xs(seed);
      e = 1 + int'(seed[3:0] % 9);
      l = pin;
      repeat (e) i_tcp_pulse_source.step(3);
      waitc(10);
      rd(tcp_pkg::COUNT_ADDR, b);
      `CHK("edge_count", 8'(a + 8'(f_edges(l, e, se[0]))), b)
    end
    // Latency of one rising edge, rising edges selected
    wr(tcp_pkg::OPTION_ADDR, 8'h29);
    if (pin === 1'b1) i_tcp_pulse_source.step(3);
    waitc(10);
    rd(tcp_pkg::COUNT_ADDR, v);
    i_tcp_pulse_source.step(1);
    waitc(1);
    rd(tcp_pkg::COUNT_ADDR, a);
    `CHK("edge_early", v, a)
    waitc(3);
    rd(tcp_pkg::COUNT_ADDR, b);
    `CHK("edge_late", 8'(v + 8'h01), b)
    // Prescaler back to the timer, dividing the pin by 2
    i_tcp_pulse_source.step(3);
    cw();
    wr(tcp_pkg::OPTION_ADDR, 8'h20);
    wr(tcp_pkg::COUNT_ADDR, 8'h00);
    waitc(10);
    rd(tcp_pkg::COUNT_ADDR, a);
    repeat (16) i_tcp_pulse_source.step(2);
    waitc(12);
    rd(tcp_pkg::COUNT_ADDR, b);
    `CHK("pin_divided", 8'(a + 8'h04), b)
    complete_run();
  end
endmodule
